// ---- core/plm_mapper.sv ----
// palette lookup mapper: register slave and panel and crt pixel paths
//
// Overview of operation
// RULE1: pixel value n addresses palette entry n.
// RULE2: each palette component holds an intensity from 0 to 0Fh.
// RULE3: intensity mapping is linear; larger component gives brighter output.
// RULE4: each primary component is four bits, sixteen levels.
// RULE5: colour depth decides how many palette entries take part, except 8 bpp mono panel uses first 16.
// RULE6: 4 bpp uses first 16 entries; each byte gives two nibble pixels.
// RULE7: 8 bpp uses a whole byte to index all 256 entries.
// RULE8: 15 and 16 bpp bypass the palette and pass pixel colours on.
// RULE9: panel is monochrome while panel config bit 2 is zero.
// RULE10: monochrome panel output comes from green only, panel path only.
// RULE11: crt output always uses red, green and blue components.
// RULE12: software sets red and blue equal to green to match crt.
// RULE13: 4 bpp gray uses green of the first 16 entries only.
// RULE14: 8 bpp gray also uses green of first 16 entries only.
// RULE15: 15 bpp gray uses five green bits; 32 or 16 shades.
// RULE16: 16 bpp gray uses six green bits; 64 or 16 shades.
// RULE17: passive colour panel loses low bits without dithering.
// RULE18: separate panel and crt palettes; mode zero reads panel, writes both.
// RULE19: index register picks one of 256 entries; writing it selects red.
// RULE20: data register carries the component in its upper nibble.
// RULE21: data accesses step red, green, blue, then index increments.
// RULE22: panel and crt lookups run independently, one triple per pixel.
`timescale 1ns/1ps
module plm_mapper (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic [11:0]           avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output      logic [31:0]           avs_readdata,
    output      logic                  avs_waitrequest,
    input  wire plm_pkg::plm_pix_in_t  panel_pix_in,
    output      logic                  panel_pix_ready,
    input  wire plm_pkg::plm_pix_in_t  crt_pix_in,
    output      logic                  crt_pix_ready,
    output      plm_pkg::plm_pix_out_t panel_pix_out,
    output      plm_pkg::plm_pix_out_t crt_pix_out
);
    logic [7:0]           panel_cfg;
    plm_pkg::plm_depth_t  depth;
    logic [7:0]           dither_cfg;
    plm_pkg::plm_target_t palette_target_select;
    logic [7:0]           palette_index;
    plm_pkg::plm_bank_t   bank;
    plm_pkg::plm_bank_t   next_bank;
    logic [7:0]           next_index;
    logic [1:0]           rd_cnt;
    logic [31:0]          rdata;
    logic [7:0]           rd_byte;
    logic [9:0]           reg_idx;
    logic                 wr_ok;
    logic                 rd_done;
    logic                 sel_panel;
    logic                 sel_depth;
    logic                 sel_dither;
    logic                 sel_target;
    logic                 sel_index;
    logic                 sel_value;
    logic                 value_access;
    logic                 mono;
    logic                 dither_on;
    logic [2:0]           lane_sel;
    logic                 wr_panel;
    logic                 wr_crt;
    logic                 rd_crt;
    plm_pkg::plm_entry_t  cpu_entry;
    logic [3:0]           cpu_comp;
    plm_pkg::plm_entry_t  cpu_q    [plm_pkg::PATH_COUNT];
    logic [2:0]           pal_lane [plm_pkg::PATH_COUNT];
    logic [7:0]           pal_addr [plm_pkg::PATH_COUNT];
    plm_pkg::plm_pix_in_t pin      [plm_pkg::PATH_COUNT];
    plm_pkg::plm_pix_out_t pout    [plm_pkg::PATH_COUNT];
    logic                 pready   [plm_pkg::PATH_COUNT];

    // address decode, one 8-bit register per aligned word
    assign reg_idx    = avs_address[11:2];
    assign wr_ok      = avs_write && avs_byteenable[0];
    assign sel_panel  = reg_idx == plm_pkg::IDX_PANEL_CFG;
    assign sel_depth  = reg_idx == plm_pkg::IDX_DEPTH_CFG;
    assign sel_dither = reg_idx == plm_pkg::IDX_DITHER_CFG;
    assign sel_target = reg_idx == plm_pkg::IDX_TARGET_SEL;
    assign sel_index  = reg_idx == plm_pkg::IDX_PAL_INDEX;
    assign sel_value  = reg_idx == plm_pkg::IDX_PAL_VALUE;

    // every read waits two cycles for the registered palette port
    assign rd_done         = avs_read && rd_cnt == plm_pkg::READ_WAIT_CYCLES;
    assign avs_waitrequest = avs_read && !rd_done;
    assign avs_readdata    = rdata;

    assign value_access = sel_value && (rd_done || wr_ok);
    assign mono         = !panel_cfg[plm_pkg::COLOR_SEL_BIT]; // see RULE9
    assign dither_on    = dither_cfg[plm_pkg::DITHER_BIT];

    // component selector and index advance
    assign next_bank = (wr_ok && sel_index) ? plm_pkg::BANK_RED : // see RULE19
                       !value_access ? bank :
                       (bank == plm_pkg::BANK_BLUE) ? plm_pkg::BANK_RED :
                       (bank == plm_pkg::BANK_RED) ? plm_pkg::BANK_GREEN :
                       plm_pkg::BANK_BLUE; // see RULE21
    assign next_index = (wr_ok && sel_index) ? avs_writedata[7:0] :
                        (value_access && bank == plm_pkg::BANK_BLUE) ?
                        palette_index + 8'h01 : palette_index; // see RULE21

    // palette write steering by target select
    assign lane_sel = (bank == plm_pkg::BANK_RED)   ? 3'h4 :
                      (bank == plm_pkg::BANK_GREEN) ? 3'h2 : 3'h1;
    assign wr_panel = sel_value && wr_ok &&
                      palette_target_select != plm_pkg::TGT_CRT; // see RULE18
    assign wr_crt   = sel_value && wr_ok &&
                      palette_target_select != plm_pkg::TGT_PANEL; // see RULE18
    assign pal_lane[plm_pkg::PATH_PANEL] = wr_panel ? lane_sel : 3'h0;
    assign pal_lane[plm_pkg::PATH_CRT]   = wr_crt ? lane_sel : 3'h0;
    assign rd_crt = palette_target_select == plm_pkg::TGT_CRT ||
                    palette_target_select == plm_pkg::TGT_BOTH_RD_CRT;
    assign cpu_entry = rd_crt ? cpu_q[plm_pkg::PATH_CRT] :
                                cpu_q[plm_pkg::PATH_PANEL]; // see RULE18
    assign cpu_comp  = (bank == plm_pkg::BANK_RED)   ? cpu_entry.red :
                       (bank == plm_pkg::BANK_GREEN) ? cpu_entry.green :
                       cpu_entry.blue;

    // read data selection, component in the upper nibble
    assign rd_byte = sel_panel  ? panel_cfg :
                     sel_depth  ? {6'h00, depth} :
                     sel_dither ? dither_cfg :
                     sel_target ? {6'h00, palette_target_select} :
                     sel_index  ? palette_index :
                     sel_value  ? {cpu_comp, 4'h0} : 8'h00; // see RULE20

    always_ff @(posedge clk) begin
        if (sys_rst || !avs_read || rd_done) begin
            rd_cnt <= 2'h0;
        end else begin
            rd_cnt <= rd_cnt + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= 32'h0000_0000;
        end else if (avs_read && !rd_done) begin
            rdata <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            panel_cfg             <= plm_pkg::PANEL_CFG_RST;
            depth                 <= plm_pkg::DEPTH_4BPP;
            dither_cfg            <= plm_pkg::DITHER_CFG_RST;
            palette_target_select <= plm_pkg::TGT_BOTH_RD_PANEL;
            palette_index         <= plm_pkg::PAL_INDEX_RST;
            bank                  <= plm_pkg::BANK_RED;
        end else begin
            if (wr_ok && sel_panel) begin
                panel_cfg <= avs_writedata[7:0];
            end
            if (wr_ok && sel_depth) begin
                depth <= plm_pkg::plm_depth_t'(avs_writedata[1:0]);
            end
            if (wr_ok && sel_dither) begin
                dither_cfg <= avs_writedata[7:0];
            end
            if (wr_ok && sel_target) begin
                palette_target_select <=
                    plm_pkg::plm_target_t'(avs_writedata[1:0]);
            end
            palette_index <= next_index;
            bank          <= next_bank;
        end
    end

    assign pin[plm_pkg::PATH_PANEL] = panel_pix_in;
    assign pin[plm_pkg::PATH_CRT]   = crt_pix_in;
    assign panel_pix_ready = pready[plm_pkg::PATH_PANEL];
    assign crt_pix_ready   = pready[plm_pkg::PATH_CRT];
    assign panel_pix_out   = pout[plm_pkg::PATH_PANEL];
    assign crt_pix_out     = pout[plm_pkg::PATH_CRT];

    // one independent lookup path per output, panel first
    for (genvar p = 0; p < plm_pkg::PATH_COUNT; p++) begin : g_path
        plm_pkg::plm_nib_t     nib;
        plm_pkg::plm_nib_t     next_nib;
        logic [3:0]            low_nib;
        logic                  s1_valid;
        logic [15:0]           s1_data;
        plm_pkg::plm_entry_t   q;
        plm_pkg::plm_pix_out_t next_out;
        logic                  take;
        logic                  fire;
        logic                  split;
        logic                  gray_mode;
        logic                  direct;
        logic [5:0]            mask;
        logic [5:0]            dr;
        logic [5:0]            dg;
        logic [5:0]            db;
        logic [5:0]            r_full;
        logic [5:0]            g_full;
        logic [5:0]            b_full;

        assign take      = pin[p].valid && nib == plm_pkg::NIB_UPPER;
        assign fire      = take || nib == plm_pkg::NIB_LOWER;
        assign pready[p] = nib == plm_pkg::NIB_UPPER;
        assign split     = depth == plm_pkg::DEPTH_4BPP; // see RULE5
        assign gray_mode = p == plm_pkg::PATH_PANEL && mono; // see RULE10
        assign direct    = depth == plm_pkg::DEPTH_15BPP ||
                           depth == plm_pkg::DEPTH_16BPP; // see RULE8
        assign mask = (p == plm_pkg::PATH_PANEL && !dither_on) ?
                      plm_pkg::MASK_TOP4 : plm_pkg::MASK_FULL; // see RULE17

        // upper nibble first, then the held lower nibble
        assign pal_addr[p] = (nib == plm_pkg::NIB_LOWER) ? {4'h0, low_nib} :
                             split ? {4'h0, pin[p].data[7:4]} : // see RULE6 RULE13
                             gray_mode ? {4'h0, pin[p].data[3:0]} : // see RULE14
                             pin[p].data[7:0]; // see RULE1 RULE7

        always_comb begin
            next_nib = nib;
            case (nib)
                plm_pkg::NIB_UPPER: begin
                    if (take && split) begin
                        next_nib = plm_pkg::NIB_LOWER; // see RULE6
                    end
                end
                plm_pkg::NIB_LOWER: begin
                    next_nib = plm_pkg::NIB_UPPER;
                end
                default: begin
                    next_nib = plm_pkg::NIB_UPPER;
                end
            endcase
        end

        // direct colour fields, left aligned to six bits
        assign dr = (depth == plm_pkg::DEPTH_16BPP) ?
                    {s1_data[15:11], 1'b0} : {s1_data[14:10], 1'b0};
        assign dg = (depth == plm_pkg::DEPTH_16BPP) ?
                    s1_data[10:5] : {s1_data[9:5], 1'b0}; // see RULE15
        assign db = {s1_data[4:0], 1'b0};
        assign r_full = direct ? dr : {q.red, 2'b00}; // see RULE3
        assign g_full = direct ? dg : {q.green, 2'b00}; // see RULE16
        assign b_full = direct ? db : {q.blue, 2'b00}; // see RULE4
        assign next_out.valid = s1_valid; // see RULE22
        assign next_out.red   = (gray_mode ? g_full : r_full) & mask;
        assign next_out.green = g_full & mask; // see RULE10
        assign next_out.blue  = (gray_mode ? g_full : b_full) & mask; // see RULE11

        plm_palette_ram u_ram (
            .clk      (clk),
            .wr_lane  (pal_lane[p]),
            .wr_addr  (palette_index),
            .wr_value (avs_writedata[7:plm_pkg::VALUE_LSB]), // see RULE2
            .pix_addr (pal_addr[p]),
            .cpu_addr (palette_index),
            .pix_q    (q),
            .cpu_q    (cpu_q[p])
        );

        always_ff @(posedge clk) begin
            if (sys_rst) begin
                nib      <= plm_pkg::NIB_UPPER;
                low_nib  <= 4'h0;
                s1_valid <= 1'b0;
                s1_data  <= 16'h0000;
                pout[p]  <= '0;
            end else begin
                nib      <= next_nib;
                s1_valid <= fire;
                pout[p]  <= next_out;
                if (take) begin
                    low_nib <= pin[p].data[3:0];
                    s1_data <= pin[p].data;
                end
            end
        end
    end

    // checks on the register side and both pixel paths
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic [4:0] crt_red_in;
    logic [3:0] panel_low_in;
    logic       no_dither;
    assign crt_red_in   = pin[plm_pkg::PATH_CRT].data[15:11];
    assign panel_low_in = pin[plm_pkg::PATH_PANEL].data[3:0];
    assign no_dither    = !dither_on;

    sequence s_split_take;
        pin[0].valid && pready[0] && depth == plm_pkg::DEPTH_4BPP;
    endsequence

    sequence s_crt_direct;
        pin[1].valid && pready[1] && depth == plm_pkg::DEPTH_16BPP
        ##1 (depth == plm_pkg::DEPTH_16BPP) [*2];
    endsequence

    a_bank_wrap: assert property ( // see RULE21
        (value_access && bank == plm_pkg::BANK_BLUE && !(wr_ok && sel_index))
        |=> bank == plm_pkg::BANK_RED &&
            palette_index == $past(palette_index) + 8'h01)
        else $error("index did not advance after the blue access");

    a_index_red: assert property ( // see RULE19
        (wr_ok && sel_index)
        |=> bank == plm_pkg::BANK_RED &&
            palette_index == $past(avs_writedata[7:0]))
        else $error("index write did not select red");

    a_value_nibble: assert property ( // see RULE20
        (sel_value && rd_done)
        |-> avs_readdata[3:0] == 4'h0 &&
            avs_readdata[31:8] == 24'h00_0000 &&
            avs_readdata[7:4] == $past(cpu_comp))
        else $error("component not in the upper nibble");

    a_target_both: assert property ( // see RULE18
        (sel_value && wr_ok &&
         palette_target_select == plm_pkg::TGT_BOTH_RD_PANEL)
        |-> pal_lane[0] != 3'h0 && pal_lane[0] == pal_lane[1] && !rd_crt)
        else $error("mode zero did not write both palettes");

    a_nibble_split: assert property ( // see RULE6
        s_split_take
        |=> !pready[0] && pal_addr[0] == {4'h0, $past(panel_low_in)}
        ##1 pready[0])
        else $error("lower nibble not looked up second");

    a_full_index: assert property ( // see RULE7
        (pin[0].valid && pready[0] && depth == plm_pkg::DEPTH_8BPP && !mono)
        |-> pal_addr[0] == pin[0].data[7:0])
        else $error("8 bpp colour index not the whole byte");

    a_gray_index: assert property ( // see RULE14
        (pready[0] && depth == plm_pkg::DEPTH_8BPP && mono)
        |-> pal_addr[0][7:4] == 4'h0)
        else $error("8 bpp gray reached beyond sixteen entries");

    a_nib_range: assert property ( // see RULE13
        (depth == plm_pkg::DEPTH_4BPP)
        |-> pal_addr[0][7:4] == 4'h0 && pal_addr[1][7:4] == 4'h0)
        else $error("4 bpp reached beyond sixteen entries");

    a_bypass_crt: assert property ( // see RULE8
        s_crt_direct
        |-> pout[1].valid && pout[1].red == {$past(crt_red_in, 2), 1'b0})
        else $error("16 bpp crt red not passed through");

    a_mono_gray: assert property ( // see RULE10
        (pout[0].valid && mono && $past(mono) && $past(mono, 2))
        |-> pout[0].red == pout[0].green && pout[0].blue == pout[0].green)
        else $error("mono panel output not from green only");

    a_panel_trim: assert property ( // see RULE17
        (pout[0].valid && no_dither && $past(no_dither) &&
         $past(no_dither, 2))
        |-> pout[0].red[1:0] == 2'h0 && pout[0].green[1:0] == 2'h0 &&
            pout[0].blue[1:0] == 2'h0)
        else $error("panel kept low bits without dithering");
endmodule

// ---- core/plm_palette_ram.sv ----
// one 256-entry palette with per-component write lanes and two read ports
`timescale 1ns/1ps
module plm_palette_ram (
    input  wire logic                clk,
    input  wire logic [2:0]          wr_lane,
    input  wire logic [7:0]          wr_addr,
    input  wire logic [3:0]          wr_value,
    input  wire logic [7:0]          pix_addr,
    input  wire logic [7:0]          cpu_addr,
    output      plm_pkg::plm_entry_t pix_q,
    output      plm_pkg::plm_entry_t cpu_q
);
    plm_pkg::plm_entry_t mem [plm_pkg::ENTRY_COUNT];

    // lane 2 red, lane 1 green, lane 0 blue
    always_ff @(posedge clk) begin
        if (wr_lane[2]) begin
            mem[wr_addr].red <= wr_value;
        end
        if (wr_lane[1]) begin
            mem[wr_addr].green <= wr_value;
        end
        if (wr_lane[0]) begin
            mem[wr_addr].blue <= wr_value;
        end
        pix_q <= mem[pix_addr];
        cpu_q <= mem[cpu_addr];
    end
endmodule

// ---- core/plm_pkg.sv ----
// shared constants and types of the palette lookup mapper
package plm_pkg;
    localparam int unsigned ENTRY_COUNT      = 256;
    localparam int unsigned PATH_COUNT       = 2;
    localparam int unsigned PATH_PANEL       = 0;
    localparam int unsigned PATH_CRT         = 1;
    localparam logic [9:0]  IDX_PANEL_CFG    = 10'h030;
    localparam logic [9:0]  IDX_DEPTH_CFG    = 10'h040;
    localparam logic [9:0]  IDX_DITHER_CFG   = 10'h041;
    localparam logic [9:0]  IDX_TARGET_SEL   = 10'h1E0;
    localparam logic [9:0]  IDX_PAL_INDEX    = 10'h1E2;
    localparam logic [9:0]  IDX_PAL_VALUE    = 10'h1E4;
    localparam int unsigned COLOR_SEL_BIT    = 2;
    localparam int unsigned DITHER_BIT       = 1;
    localparam int unsigned VALUE_LSB        = 4;
    localparam logic [7:0]  PANEL_CFG_RST    = 8'h00;
    localparam logic [7:0]  DITHER_CFG_RST   = 8'h00;
    localparam logic [7:0]  PAL_INDEX_RST    = 8'h00;
    localparam logic [1:0]  READ_WAIT_CYCLES = 2'h2;
    localparam logic [5:0]  MASK_FULL        = 6'h3F;
    localparam logic [5:0]  MASK_TOP4        = 6'h3C;

    typedef enum logic [1:0] {
        DEPTH_4BPP,
        DEPTH_8BPP,
        DEPTH_15BPP,
        DEPTH_16BPP
    } plm_depth_t;

    typedef enum logic [1:0] {
        BANK_RED,
        BANK_GREEN,
        BANK_BLUE
    } plm_bank_t;

    typedef enum logic [1:0] {
        TGT_BOTH_RD_PANEL,
        TGT_PANEL,
        TGT_CRT,
        TGT_BOTH_RD_CRT
    } plm_target_t;

    typedef enum logic {
        NIB_UPPER,
        NIB_LOWER
    } plm_nib_t;

    typedef struct packed {
        logic [3:0] red;
        logic [3:0] green;
        logic [3:0] blue;
    } plm_entry_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } plm_pix_in_t;

    typedef struct packed {
        logic       valid;
        logic [5:0] red;
        logic [5:0] green;
        logic [5:0] blue;
    } plm_pix_out_t;
endpackage

// ---- tb/plm_display_model.sv ----
// sink model of one display output path, counting delivered pixels
`timescale 1ns/1ps
module plm_display_model (
    input  wire logic                  clk,
    input  wire plm_pkg::plm_pix_out_t pix,
    output      int                    count
);
    int n = 0;
    assign count = n;
    always @(posedge clk) begin
        if (pix.valid === 1'b1) begin
            n <= n + 1;
        end
    end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the palette lookup mapper
`timescale 1ns/1ps
module tb_top;
    logic                  clk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic [11:0]           adr = 12'h000;
    logic                  rd_s = 1'b0;
    logic                  wr_s = 1'b0;
    logic [31:0]           wdat = 32'h0;
    logic [3:0]            be = 4'h0;
    logic [31:0]           rdat;
    logic                  wait_s;
    plm_pkg::plm_pix_in_t  pin = '0;
    logic                  p_rdy;
    logic                  c_rdy;
    plm_pkg::plm_pix_out_t pout;
    plm_pkg::plm_pix_out_t cout;
    int                    mismatches = 0;
    int                    n_compared = 0;
    int                    p_cnt;
    int                    c_cnt;
    int                    n_pix = 0;
    int                    pr [256];
    int                    cr [256];
    int                    col;
    int                    dep;
    int                    dit;
    bit                    match = 1'b0;
    logic [31:0]           lf = 32'h0001_7983;
    logic [31:0]           q;
    always #20 clk = ~clk;
    plm_mapper u_plm_mapper (.clk(clk), .sys_rst(sys_rst),
        .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
        .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wait_s), .panel_pix_in(pin),
        .panel_pix_ready(p_rdy), .crt_pix_in(pin), .crt_pix_ready(c_rdy),
        .panel_pix_out(pout), .crt_pix_out(cout));
    plm_display_model u_plm_display_model (.clk(clk), .pix(pout),
        .count(p_cnt));
    plm_display_model u_plm_display_model_crt (.clk(clk), .pix(cout),
        .count(c_cnt));
    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(logic [31:0] s, logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(bit w, logic [9:0] i, logic [7:0] d, bit b);
        int k;
        adr <= {i, 2'b00};
        wdat <= {24'h0, d};
        be <= {3'b000, b};
        rd_s <= !w;
        wr_s <= w;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (wait_s === 1'b0) break;
        end
        if (k == 20) begin
            mismatches++;
            end_sim();
        end
        q = rdat;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic load(int t, int f, int n, bit g);
        int k, v, s, a, w;
        bus(1, plm_pkg::IDX_TARGET_SEL, 8'(t), 1);
        bus(1, plm_pkg::IDX_PAL_INDEX, 8'(f), 1);
        for (k = 0; k < 3 * n; k++) begin
            if (!g || k % 3 == 0) w = rnd() & 255;
            bus(1, plm_pkg::IDX_PAL_VALUE, 8'(w), 1);
            s = 8 - 4 * (k % 3);
            a = (f + k / 3) & 255;
            v = (w >> 4) << s;
            if (t != 2) pr[a] = (pr[a] & ~(15 << s)) | v;
            if (t != 1) cr[a] = (cr[a] & ~(15 << s)) | v;
        end
    endtask
    task automatic rb(int t, int i);
        int k, e;
        e = (t >= 2) ? cr[i] : pr[i];
        bus(1, plm_pkg::IDX_TARGET_SEL, 8'(t), 1);
        bus(1, plm_pkg::IDX_PAL_INDEX, 8'(i), 1);
        for (k = 0; k < 3; k++) begin
            bus(0, plm_pkg::IDX_PAL_VALUE, 8'h00, 1);
            chk(q, ((e >> (8 - 4 * k)) & 15) << 4);
        end
        bus(0, plm_pkg::IDX_PAL_INDEX, 8'h00, 1);
        chk(q, i + 1);
    endtask
    function automatic logic [31:0] px(int p, int v);
        int e, r, g, b;
        e = p ? cr[v & 255] : pr[v & 255];
        if (p == 0 && col == 0) e = pr[v & 15];
        r = (e >> 8 & 15) << 2;
        g = (e >> 4 & 15) << 2;
        b = (e & 15) << 2;
        if (dep == 2) begin
            r = (v >> 10 & 31) << 1;
            g = (v >> 5 & 31) << 1;
            b = (v & 31) << 1;
        end
        if (dep == 3) begin
            r = (v >> 11 & 31) << 1;
            g = v >> 5 & 63;
            b = (v & 31) << 1;
        end
        if (p == 0 && col == 0) begin
            r = g;
            b = g;
        end
        if (p == 0 && dit == 0) begin
            r = r & 60;
            g = g & 60;
            b = b & 60;
        end
        return {14'h0, r[5:0], g[5:0], b[5:0]};
    endfunction
    task automatic send(logic [15:0] v);
        int k, j, pv;
        pin <= '{1'b1, v};
        @(negedge clk);
        chk(p_rdy & c_rdy, 1);
        @(posedge clk);
        pin.valid <= 1'b0;
        for (j = 0; j < ((dep == 0) ? 2 : 1); j++) begin
            pv = (dep == 0) ? (j ? v[3:0] : v[7:4]) : v;
            if (dep == 1) pv = v[7:0];
            for (k = 0; k < 8; k++) begin
                @(negedge clk);
                if (j == 0 && k == 0 && dep == 0) chk(p_rdy, 0);
                if (pout.valid === 1'b1) break;
            end
            if (k == 8) begin
                mismatches++;
                end_sim();
            end
            n_pix++;
            chk(cout.valid, 1);
            chk({pout.red, pout.green, pout.blue}, px(0, pv));
            chk({cout.red, cout.green, cout.blue}, px(1, pv));
            if (match) chk(cout[17:0], px(0, pv));
        end
        @(posedge clk);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        bus(0, plm_pkg::IDX_PANEL_CFG, 8'h00, 1);
        chk(q, plm_pkg::PANEL_CFG_RST);
        bus(1, 10'h3FF, 8'hFF, 1);
        bus(0, 10'h3FF, 8'h00, 1);
        chk(q, 0);
        load(0, 0, 256, 0);
        load(1, 0, 16, 0);
        load(2, 16, 16, 0);
        rb(0, 15);
        rb(0, 20);
        rb(2, 20);
        rb(3, 15);
        bus(1, plm_pkg::IDX_PAL_INDEX, 8'h20, 1);
        bus(0, plm_pkg::IDX_PAL_VALUE, 8'h00, 1);
        bus(1, plm_pkg::IDX_PAL_INDEX, 8'h20, 1);
        bus(0, plm_pkg::IDX_PAL_VALUE, 8'h00, 1);
        chk(q, (cr[32] >> 8) << 4);
        bus(1, plm_pkg::IDX_PAL_INDEX, 8'h55, 0);
        bus(0, plm_pkg::IDX_PAL_INDEX, 8'h00, 1);
        chk(q, 32'h20);
        for (col = 1; col >= 0; col--) begin
            for (dit = 0; dit < 2; dit++) begin
                for (dep = 0; dep < 4; dep++) begin
                    bus(1, plm_pkg::IDX_PANEL_CFG, 8'(col * 4), 1);
                    bus(1, plm_pkg::IDX_DEPTH_CFG, 8'(dep), 1);
                    bus(1, plm_pkg::IDX_DITHER_CFG, 8'(dit * 2), 1);
                    repeat (4) send(16'(rnd()));
                end
            end
        end
        load(0, 0, 16, 1);
        col = 0;
        dit = 1;
        dep = 0;
        match = 1'b1;
        bus(1, plm_pkg::IDX_PANEL_CFG, 8'h00, 1);
        bus(1, plm_pkg::IDX_DEPTH_CFG, 8'h00, 1);
        bus(1, plm_pkg::IDX_DITHER_CFG, 8'h02, 1);
        repeat (4) send(16'(rnd()));
        repeat (3) @(posedge clk);
        chk(p_cnt, n_pix);
        chk(c_cnt, n_pix);
        end_sim();
    end
endmodule
